// ---- hw/ocf_frames.sv ----
// Serial frame receiver and store for the channel 3 and channel 4 configuration frames
`timescale 1ns/1ns
module ocf_frames
  import ocf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Context from the rest of the device, on ref_clk
  input wire logic [1:0] ch1_tdiag_code,
  input wire logic bridge_a_timer_sharing,
  input wire logic ch3_oc_event,
  input wire logic ch4_oc_event,
  input wire logic [5:0] ch3_actual_threshold,
  input wire logic [5:0] ch4_actual_threshold,
  // Stored frames
  output logic [31:0] channel3_configuration,
  output logic [31:0] channel4_configuration,
  // Effective per-channel settings
  output logic [1:0] ch3_tdiag_eff,
  output logic [1:0] ch4_tdiag_eff,
  output logic ch3_reengage_eff,
  output logic ch4_reengage_eff,
  output logic [1:0] ch3_gate_current_eff,
  output logic [1:0] ch4_gate_current_eff,
  // First bridge and peak-and-hold settings
  output logic bridge_a_enable,
  output logic bridge_a_current_limit_on,
  output logic bridge_a_active_freewheel,
  output logic peak_hold_a_enable,
  output logic peak_hold_a_masking_policy,
  // Frame events
  output logic frame_accepted,
  output logic frame_error
);

  ocf_state_t state;
  ocf_state_t next_state;

  logic [2:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] mosi_sync;
  logic cs_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  logic [31:0] rx_shift;
  logic [5:0] bit_cnt;
  logic [31:0] tx_shift;
  logic [31:0] pending_resp;
  logic [3:0] last_cmd;
  logic last_ok;

  logic [3:0] rx_cmd;
  logic rx_parity_ok;
  logic rx_ours;
  logic rx_full;
  logic [31:0] resp_src;
  logic [5:0] resp_thr;
  logic [31:0] next_resp;

  ocf_chan_if ch3_if ();
  ocf_chan_if ch4_if ();

  // Link pins cross into ref_clk through two flops before any use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_sync <= 3'h0;
      cs_sync <= 2'h3;
      mosi_sync <= 2'h0;
      cs_prev <= 1'b1;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      cs_sync <= {cs_sync[0], cs_n};
      mosi_sync <= {mosi_sync[0], mosi};
      cs_prev <= cs_sync[1];
    end
  end

  // Edges are found on the second and third stages only
  assign sclk_rise = sclk_sync[1] && !sclk_sync[2];
  assign sclk_fall = !sclk_sync[1] && sclk_sync[2];
  assign cs_fall = !cs_sync[1] && cs_prev;
  assign cs_rise = cs_sync[1] && !cs_prev;

  // Frame checks on the received word
  assign rx_cmd = rx_shift[CMD_MSB:CMD_LSB];
  assign rx_parity_ok = ^rx_shift;
  assign rx_ours = (rx_cmd == CMD_CH3) || (rx_cmd == CMD_CH4);
  assign rx_full = (bit_cnt == FRAME_LEN);

  // Frame sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          next_state = ST_APPLY;
        end
      end
      ST_APPLY: begin
        next_state = ST_RESP;
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Receive shifter: MSB first, sampled on the rising link clock edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_shift <= 32'h0000_0000;
      bit_cnt <= 6'h00;
    end else if (state == ST_IDLE && cs_fall) begin
      rx_shift <= 32'h0000_0000;
      bit_cnt <= 6'h00;
    end else if (state == ST_SHIFT && sclk_rise) begin
      rx_shift <= {rx_shift[30:0], mosi_sync[1]};
      if (bit_cnt != CNT_SAT) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // Channel 3 store; bad parity or read-only leaves it untouched
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      channel3_configuration <= CFG_RESET;
    end else if (state == ST_APPLY && rx_full && rx_cmd == CMD_CH3) begin
      if (rx_parity_ok && !rx_shift[RW_BIT]) begin
        channel3_configuration <= rx_shift;
      end
    end
  end

  // Channel 4 store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      channel4_configuration <= CFG_RESET;
    end else if (state == ST_APPLY && rx_full && rx_cmd == CMD_CH4) begin
      if (rx_parity_ok && !rx_shift[RW_BIT]) begin
        channel4_configuration <= rx_shift;
      end
    end
  end

  // Remember what the frame asked for; the answer is built one cycle later
  // so that a write is reflected in its own readback
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_cmd <= 4'h0;
      last_ok <= 1'b0;
    end else if (state == ST_APPLY) begin
      last_cmd <= rx_cmd;
      last_ok <= rx_full && rx_ours && rx_parity_ok;
    end
  end

  // Frame event pulses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_accepted <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      frame_accepted <= state == ST_APPLY && rx_full && rx_ours && rx_parity_ok;
      frame_error <= state == ST_APPLY && rx_full && rx_ours && !rx_parity_ok;
    end
  end

  // Channel decoders
  assign ch3_if.cfg = channel3_configuration;
  assign ch3_if.bridge_en = channel4_configuration[HI_B26];
  assign ch3_if.timer_sharing = bridge_a_timer_sharing;
  assign ch3_if.ch1_tdiag = ch1_tdiag_code;
  assign ch3_if.boost_global = channel3_configuration[HI_B24];
  assign ch3_if.oc_event = ch3_oc_event;
  assign ch3_if.actual_thr = ch3_actual_threshold;

  assign ch4_if.cfg = channel4_configuration;
  assign ch4_if.bridge_en = channel4_configuration[HI_B26];
  assign ch4_if.timer_sharing = bridge_a_timer_sharing;
  assign ch4_if.ch1_tdiag = ch1_tdiag_code;
  assign ch4_if.boost_global = channel3_configuration[HI_B24];
  assign ch4_if.oc_event = ch4_oc_event;
  assign ch4_if.actual_thr = ch4_actual_threshold;

  ocf_chan_decode u_ch3_decode (
    .ch(ch3_if.dec)
  );

  ocf_chan_decode u_ch4_decode (
    .ch(ch4_if.dec)
  );

  // Answer frame: stored word with the chosen threshold and fresh parity
  always_comb begin
    if (last_cmd == CMD_CH4) begin
      resp_src = channel4_configuration;
      resp_thr = ch4_if.thr_readback;
    end else begin
      resp_src = channel3_configuration;
      resp_thr = ch3_if.thr_readback;
    end
    next_resp = {last_cmd, resp_src[RW_BIT:THR_SEL_BIT], resp_thr,
                 resp_src[TCOMP_MSB:EN_BIT], 1'b0};
    next_resp[PAR_BIT] = ~^next_resp[31:1];
    if (!last_ok) begin
      next_resp = RESP_NONE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_resp <= RESP_NONE;
    end else if (state == ST_RESP) begin
      pending_resp <= next_resp;
    end
  end

  // Transmit shifter: answer goes out during the next frame, changing on falling edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_shift <= RESP_NONE;
      miso <= 1'b0;
    end else if (state == ST_IDLE && cs_fall) begin
      tx_shift <= pending_resp;
      miso <= pending_resp[31];
    end else if (state == ST_SHIFT && sclk_fall) begin
      tx_shift <= {tx_shift[30:0], 1'b0};
      miso <= tx_shift[30];
    end
  end

  // Data out is driven only while the frame is selected
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      miso_oe_n <= 1'b1;
    end else if (state == ST_IDLE && cs_fall) begin
      miso_oe_n <= 1'b0;
    end else if (cs_rise) begin
      miso_oe_n <= 1'b1;
    end
  end

  // Effective per-channel settings, registered so the outputs come from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ch3_tdiag_eff <= 2'h0;
      ch4_tdiag_eff <= 2'h0;
    end else begin
      ch3_tdiag_eff <= ch3_if.eff_tdiag;
      ch4_tdiag_eff <= ch4_if.eff_tdiag;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ch3_reengage_eff <= 1'b0;
      ch4_reengage_eff <= 1'b0;
    end else begin
      ch3_reengage_eff <= ch3_if.eff_reengage;
      ch4_reengage_eff <= ch4_if.eff_reengage;
    end
  end

  // Boost follows the overcurrent flag with one cycle of latency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ch3_gate_current_eff <= GCC_EXT;
      ch4_gate_current_eff <= GCC_EXT;
    end else begin
      ch3_gate_current_eff <= ch3_if.eff_gate_current;
      ch4_gate_current_eff <= ch4_if.eff_gate_current;
    end
  end

  // First bridge settings; current limit needs shunt sensing on channel 3
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bridge_a_current_limit_on <= 1'b0;
      bridge_a_active_freewheel <= 1'b0;
    end else begin
      bridge_a_current_limit_on <= channel3_configuration[HI_B26]
                                   && channel3_configuration[SENSE_BIT];
      bridge_a_active_freewheel <= channel3_configuration[HI_B25];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bridge_a_enable <= 1'b0;
      peak_hold_a_masking_policy <= 1'b0;
      peak_hold_a_enable <= 1'b0;
    end else begin
      bridge_a_enable <= channel4_configuration[HI_B26];
      peak_hold_a_masking_policy <= channel4_configuration[HI_B25];
      peak_hold_a_enable <= channel4_configuration[HI_B24];
    end
  end

  // Threshold, compensation, blanking, open-load current, transistor, side and enable
  // fields leave as part of the stored words; the channel drivers decode them there.

endmodule

// ---- hw/ocf_pkg.sv ----
// Constants and types shared by the channel 3/4 configuration frame logic
package ocf_pkg;

  // Frame geometry
  localparam logic [5:0] FRAME_LEN = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h3f;

  // Command codes in bits 31:28
  localparam logic [3:0] CMD_CH3 = 4'h3;
  localparam logic [3:0] CMD_CH4 = 4'h4;

  // Field positions common to both frames
  localparam int CMD_MSB = 31;
  localparam int CMD_LSB = 28;
  localparam int RW_BIT = 27;
  localparam int HI_B26 = 26;
  localparam int HI_B25 = 25;
  localparam int HI_B24 = 24;
  localparam int TDIAG_MSB = 23;
  localparam int TDIAG_LSB = 22;
  localparam int THR_SEL_BIT = 21;
  localparam int THR_MSB = 20;
  localparam int THR_LSB = 15;
  localparam int TCOMP_MSB = 14;
  localparam int TCOMP_LSB = 13;
  localparam int SUPPLY_BIT = 12;
  localparam int BLANK_MSB = 11;
  localparam int BLANK_LSB = 9;
  localparam int REENG_BIT = 8;
  localparam int SENSE_BIT = 7;
  localparam int OL_CUR_BIT = 6;
  localparam int GCC_MSB = 5;
  localparam int GCC_LSB = 4;
  localparam int PCH_BIT = 3;
  localparam int SIDE_BIT = 2;
  localparam int EN_BIT = 1;
  localparam int PAR_BIT = 0;

  // Gate current select codes
  localparam logic [1:0] GCC_EXT = 2'h0;
  localparam logic [1:0] GCC_20MA = 2'h1;
  localparam logic [1:0] GCC_5MA = 2'h2;
  localparam logic [1:0] GCC_1MA = 2'h3;

  // Reset value of both stored frames and the empty answer frame
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] RESP_NONE = 32'h0000_0001;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_APPLY, ST_RESP} ocf_state_t;

endpackage

// ---- hw/ocf_chan_if.sv ----
// Carrier between the frame logic and one channel decoder
`timescale 1ns/1ns
interface ocf_chan_if;
  logic [31:0] cfg;
  logic bridge_en;
  logic timer_sharing;
  logic [1:0] ch1_tdiag;
  logic boost_global;
  logic oc_event;
  logic [5:0] actual_thr;
  logic [1:0] eff_tdiag;
  logic eff_reengage;
  logic [1:0] eff_gate_current;
  logic [5:0] thr_readback;

  modport ctl (
    output cfg, bridge_en, timer_sharing, ch1_tdiag, boost_global, oc_event, actual_thr,
    input eff_tdiag, eff_reengage, eff_gate_current, thr_readback
  );
  modport dec (
    input cfg, bridge_en, timer_sharing, ch1_tdiag, boost_global, oc_event, actual_thr,
    output eff_tdiag, eff_reengage, eff_gate_current, thr_readback
  );
endinterface

// ---- hw/ocf_chan_decode.sv ----
// Per-channel decode of a stored configuration frame into effective settings
`timescale 1ns/1ns
module ocf_chan_decode
  import ocf_pkg::*;
(
  // Channel context and results
  ocf_chan_if.dec ch
);

  logic [1:0] gcc;

  assign gcc = ch.cfg[GCC_MSB:GCC_LSB];

  // Bridge with shared timers takes the channel-1 timer code
  always_comb begin
    if (ch.bridge_en && !ch.timer_sharing) begin
      ch.eff_tdiag = ch.ch1_tdiag;
    end else begin
      ch.eff_tdiag = ch.cfg[TDIAG_MSB:TDIAG_LSB];
    end
  end

  // A bridge always waits for a latch clear before re-engaging
  always_comb begin
    if (ch.bridge_en) begin
      ch.eff_reengage = 1'b1;
    end else begin
      ch.eff_reengage = ch.cfg[REENG_BIT];
    end
  end

  // Gate current boost while an overcurrent is flagged; external limit is untouched
  always_comb begin
    ch.eff_gate_current = gcc;
    if (ch.oc_event && gcc != GCC_EXT) begin
      if (ch.boost_global || gcc == GCC_5MA) begin
        ch.eff_gate_current = GCC_20MA;
      end else if (gcc == GCC_1MA) begin
        ch.eff_gate_current = GCC_5MA;
      end
    end
  end

  // Threshold returned on readback
  always_comb begin
    if (ch.cfg[THR_SEL_BIT]) begin
      ch.thr_readback = ch.actual_thr;
    end else begin
      ch.thr_readback = ch.cfg[THR_MSB:THR_LSB];
    end
  end

endmodule

// ---- dv/ocf_frames_properties.sv ----
// Concurrent checks on the channel 3/4 configuration frame ports
`timescale 1ns/1ns
module ocf_frames_checker
  import ocf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Link and context
  input wire logic cs_n,
  input wire logic miso_oe_n,
  input wire logic [1:0] ch1_tdiag_code,
  input wire logic bridge_a_timer_sharing,
  input wire logic ch3_oc_event,
  // Stored frames and results
  input wire logic [31:0] channel3_configuration,
  input wire logic [31:0] channel4_configuration,
  input wire logic [1:0] ch3_tdiag_eff,
  input wire logic ch3_reengage_eff,
  input wire logic ch4_reengage_eff,
  input wire logic [1:0] ch3_gate_current_eff,
  input wire logic bridge_a_enable,
  input wire logic bridge_a_current_limit_on,
  input wire logic bridge_a_active_freewheel,
  input wire logic peak_hold_a_enable,
  input wire logic peak_hold_a_masking_policy,
  input wire logic frame_accepted
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Outputs are registered after the store, so two quiet edges are awaited
  sequence cfg3_settled;
    $stable(channel3_configuration) ##1 $stable(channel3_configuration);
  endsequence
  sequence cfg4_settled;
    $stable(channel4_configuration) ##1 $stable(channel4_configuration);
  endsequence
  sequence timers_shared;
    (bridge_a_enable && !bridge_a_timer_sharing && $stable(ch1_tdiag_code))[*3];
  endsequence
  sequence gate_quiet;
    (!ch3_oc_event && $stable(channel3_configuration))[*3];
  endsequence

  oe_idle_a: assert property (cs_n[*5] |-> miso_oe_n)
    else $error("miso driven outside a frame");
  accept_single_a: assert property (frame_accepted |=> !frame_accepted)
    else $error("accept pulse longer than one cycle");
  store_on_accept_a: assert property ((!$stable(channel3_configuration)
    || !$stable(channel4_configuration)) |-> frame_accepted)
    else $error("stored frame changed without acceptance");
  stored3_frame_a: assert property (!$stable(channel3_configuration) |->
    channel3_configuration[CMD_MSB:CMD_LSB] == CMD_CH3 && !channel3_configuration[RW_BIT]
    && ^channel3_configuration) else $error("bad frame stored for channel 3");
  stored4_frame_a: assert property (!$stable(channel4_configuration) |->
    channel4_configuration[CMD_MSB:CMD_LSB] == CMD_CH4 && !channel4_configuration[RW_BIT]
    && ^channel4_configuration) else $error("bad frame stored for channel 4");
  bridge3_bits_a: assert property (cfg3_settled |->
    bridge_a_current_limit_on == (channel3_configuration[26] && channel3_configuration[7])
    && bridge_a_active_freewheel == channel3_configuration[25])
    else $error("bridge limit or freewheel mismatch");
  bridge4_bits_a: assert property (cfg4_settled |->
    {bridge_a_enable, peak_hold_a_masking_policy, peak_hold_a_enable}
    == channel4_configuration[26:24]) else $error("bridge or peak-hold mismatch");
  bridge_reengage_a: assert property (bridge_a_enable[*3] |->
    ch3_reengage_eff && ch4_reengage_eff) else $error("bridge re-engagement not forced");
  shared_timer_a: assert property (timers_shared |-> ch3_tdiag_eff == ch1_tdiag_code)
    else $error("shared timer not applied");
  gate_plain_a: assert property (gate_quiet |->
    ch3_gate_current_eff == channel3_configuration[GCC_MSB:GCC_LSB])
    else $error("gate current changed without overcurrent");
endmodule

bind ocf_frames ocf_frames_checker chk (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
  .miso_oe_n(miso_oe_n), .ch1_tdiag_code(ch1_tdiag_code),
  .bridge_a_timer_sharing(bridge_a_timer_sharing), .ch3_oc_event(ch3_oc_event),
  .channel3_configuration(channel3_configuration),
  .channel4_configuration(channel4_configuration), .ch3_tdiag_eff(ch3_tdiag_eff),
  .ch3_reengage_eff(ch3_reengage_eff), .ch4_reengage_eff(ch4_reengage_eff),
  .ch3_gate_current_eff(ch3_gate_current_eff), .bridge_a_enable(bridge_a_enable),
  .bridge_a_current_limit_on(bridge_a_current_limit_on),
  .bridge_a_active_freewheel(bridge_a_active_freewheel),
  .peak_hold_a_enable(peak_hold_a_enable),
  .peak_hold_a_masking_policy(peak_hold_a_masking_policy),
  .frame_accepted(frame_accepted));

// ---- dv/ocf_host_model.sv ----
// Host model that sends 32-bit frames on the serial link
`timescale 1ns/1ns
module ocf_host_model (
  // Clock
  input wire logic ref_clk,
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Sends hi as bits 31:1; parity is good unless bad is set
  task automatic xfer(input logic [30:0] hi, input logic bad, output logic [31:0] rx);
    logic [31:0] tx;
    tx = {hi, (~^hi) ^ bad};
    cs_n <= 1'b0;
    wait_clk(4);
    for (int i = 31; i >= 0; i--) begin
      mosi <= tx[i];
      wait_clk(4);
      rx[i] = miso_oe_n ? 1'bx : miso;
      sclk <= 1'b1;
      wait_clk(4);
      sclk <= 1'b0;
    end
    wait_clk(4);
    cs_n <= 1'b1;
    // A released line must not keep looking like valid data
    mosi <= ~tx[0];
    wait_clk(12);
  endtask
endmodule

// ---- dv/ocf_frames_test.sv ----
// Self-checking bench for the channel 3/4 configuration frame block
`timescale 1ns/1ns
module ocf_frames_test;
  import ocf_pkg::*;
  typedef struct packed {logic [31:0] f; logic oc; logic [1:0] gce;} ocf_row_t;
  // Channel 3 writes: frame, overcurrent level, expected gate current code
  localparam ocf_row_t ROWS [7] = '{'{32'h3020_0030, 1'b1, 2'h2},
    '{32'h301f_8020, 1'b1, 2'h1}, '{32'h3100_0030, 1'b1, 2'h1},
    '{32'h3100_0020, 1'b1, 2'h1}, '{32'h3100_7fce, 1'b1, 2'h0},
    '{32'h3600_00b0, 1'b0, 2'h3}, '{32'h30c0_0010, 1'b1, 2'h1}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] ch1_tdiag_code = 2'h0;
  logic bridge_a_timer_sharing = 1'b1;
  logic ch3_oc_event = 1'b0;
  logic ch4_oc_event = 1'b0;
  logic [5:0] thr3 = 6'h2a;
  logic [5:0] thr4 = 6'h15;
  logic sclk, cs_n, mosi, miso, miso_oe_n;
  logic [31:0] cfg3, cfg4, rx, exp_ans;
  logic [1:0] td3, td4, gc3, gc4;
  logic re3, re4, br_en, lim, afw, ph_en, ph_mask, acc, err;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_acc = 0;
  int n_err = 0;

  ocf_frames dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .ch1_tdiag_code(ch1_tdiag_code),
    .bridge_a_timer_sharing(bridge_a_timer_sharing), .ch3_oc_event(ch3_oc_event),
    .ch4_oc_event(ch4_oc_event), .ch3_actual_threshold(thr3), .ch4_actual_threshold(thr4),
    .channel3_configuration(cfg3), .channel4_configuration(cfg4), .ch3_tdiag_eff(td3),
    .ch4_tdiag_eff(td4), .ch3_reengage_eff(re3), .ch4_reengage_eff(re4),
    .ch3_gate_current_eff(gc3), .ch4_gate_current_eff(gc4), .bridge_a_enable(br_en),
    .bridge_a_current_limit_on(lim), .bridge_a_active_freewheel(afw),
    .peak_hold_a_enable(ph_en), .peak_hold_a_masking_policy(ph_mask),
    .frame_accepted(acc), .frame_error(err));
  ocf_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (acc === 1'b1) n_acc++;
    if (err === 1'b1) n_err++;
  end

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    cmp(cfg3 | cfg4, CFG_RESET);
    for (int i = 0; i < 7; i++) begin
      ch3_oc_event <= ROWS[i].oc;
      host.xfer(ROWS[i].f[31:1], 1'b0, rx);
      exp_ans = {ROWS[i].f[31:1], ~^ROWS[i].f[31:1]};
      cmp(cfg3, exp_ans);
      cmp({30'h0, gc3}, {30'h0, ROWS[i].gce});
      cmp({30'h0, lim, afw},
        {30'h0, exp_ans[HI_B26] & exp_ans[SENSE_BIT], exp_ans[HI_B25]});
      if (exp_ans[THR_SEL_BIT]) exp_ans[THR_MSB:THR_LSB] = thr3;
      exp_ans[PAR_BIT] = ~^exp_ans[31:1];
      host.xfer(31'h1c00_0000, 1'b0, rx);
      cmp(rx, exp_ans);
    end
    // Bad parity, unknown command and read-only frames must not store
    exp_ans = {ROWS[6].f[31:1], ~^ROWS[6].f[31:1]};
    host.xfer(31'h1800_0001, 1'b1, rx);
    host.xfer(31'h2800_0001, 1'b0, rx);
    cmp(rx, RESP_NONE);
    host.xfer(31'h1c00_0001, 1'b0, rx);
    cmp(rx, RESP_NONE);
    cmp(cfg3, exp_ans);
    cmp({n_acc[15:0], n_err[15:0]}, 32'h000f_0001);
    // Bridge on with the channel 1 timer shared
    ch1_tdiag_code <= 2'h2;
    bridge_a_timer_sharing <= 1'b0;
    ch4_oc_event <= 1'b1;
    host.xfer(31'h23b0_0001, 1'b0, rx);
    cmp({29'h0, br_en, ph_mask, ph_en}, 32'h7);
    cmp({26'h0, td3, td4, re3, re4}, 32'h2b);
    cmp({30'h0, gc4}, {30'h0, GCC_EXT});
    // Channel 4 readback with the actual threshold selected
    host.xfer(31'h2400_0000, 1'b0, rx);
    cmp(rx, 32'h476a_8003);
    bridge_a_timer_sharing <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp({28'h0, td3, td4}, 32'hd);
    // Reset in mid-run clears both stored frames
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cmp({cfg3 | cfg4}, CFG_RESET);
    cmp({31'h0, miso_oe_n}, 32'h1);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // First frame after the second reset: empty answer, write lands
    host.xfer(ROWS[0].f[31:1], 1'b0, rx);
    cmp(rx, RESP_NONE);
    cmp(cfg3, {ROWS[0].f[31:1], ~^ROWS[0].f[31:1]});
    stop_test();
  end
endmodule
